// ### design/content_protect_tx_control.sv
/*
  content-protection transmitter control: configuration and control
  registers, authentication handshakes with software, encryption gating,
  mute, receiver wait timer and a maskable interrupt.
  assumes: the authentication engine and cipher share core_clk and give
  one-cycle event pulses; the in-band encryption line is an async pin.
*/
`timescale 1ns/1ns

// Function
// R1: the two-bit mode field at bits 4:3 selects encrypt-when-authenticated, register control, always, or per-frame in-band control.
// R2: with the wait enable bit at 2 set a 100 ms timer runs before encryption starts, and with it clear there is no wait.
// R3: the mute bit at 0 puts the transmitter in mute, ignoring encryption status controls, and clearing it resumes normal operation;
// the code still lets an encryption disable write clear encrypt_on and blue_screen during mute.
// R4: software may set mute only while enhanced status signalling is selected; the code stores the mute bit whatever configuration bit 6 holds.
// R5: writing one to bit 7 resets the protection transmitter and disables authentication, then the bit clears itself.
// R6: software sets the list approval bit 5 after checking the repeater list, and the device then completes authentication and clears it.
// R7: software sets the key approval bit 4 after checking the receiver key, a zero write does nothing, and the bit clears when key ready asserts.
// R8: writing one to bit 3 sends video unencrypted while keeping authentication, and the bit clears itself.
// R9: with encryption enable bit 2 set video is encrypted when authenticated and blue otherwise, and with it clear video is plain.
// R10: in always-encrypt mode the encryption enable bit is read-only and reads one.
// R11: software should keep encryption enabled whenever it sends protected video.
// R12: writing one to bit 1 of the control register disables authentication and the bit clears itself.
// R13: writing one to bit 0 enables or restarts authentication, a zero does nothing, and a read shows the enabled status.
// R14: configuration bit 6 selects enhanced status signalling when one and original signalling when zero.
// R15: when not a repeater the device raises key ready once the key is read and pauses until key approval.
// R16: when the repeater list is read the device raises list ready and waits for list approval.
// R17: self-clearing bits read back as zero once their action has been issued.
module content_protect_tx_control
  import protect_ctl_pkg::*;
#(
  parameter int unsigned WAIT_COUNT = WAIT_CYCLES
)
(
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // authentication engine status
  input  wire logic              is_repeater,
  input  wire logic              authenticated,
  input  wire logic              key_read_evt,
  input  wire logic              list_read_evt,
  input  wire logic              cipher_init_evt,
  // video timing and in-band encryption request
  input  wire logic              frame_start,
  input  wire logic              inband_encrypt_pin,
  // authentication engine commands
  output logic                   protect_reset,
  output logic                   auth_start,
  output logic                   auth_restart,
  output logic                   auth_stop,
  output logic                   auth_paused,
  output logic                   key_release,
  output logic                   list_release,
  // video path control
  output logic                   encrypt_on,
  output logic                   blue_screen,
  output logic                   mute_active,
  output logic                   enhanced_signalling,
  output logic                   cipher_wait,
  // interrupt
  output logic                   irq
);

  typedef struct packed
  {
    logic [7:0]        cfg;
    logic              enc_en;
    logic              auth_en;
    logic              key_ok;
    logic              list_ok;
    logic              key_rdy;
    logic              list_rdy;
    logic              authed_d;
    logic              inband;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_mask;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              rst_p;
    logic              start_p;
    logic              restart_p;
    logic              stop_p;
    logic              key_rel_p;
    logic              list_rel_p;
    logic              encrypt;
    logic              blue;
    logic              mute;
    logic              enh;
    logic              paused;
    logic              waiting;
  } ctl_t;

  ctl_t       st_ff;
  ctl_t       nxt_st;
  logic       inband_sync;
  logic       wait_busy;
  logic       wait_done;
  logic       wr_cfg;
  logic       wr_ctl;
  logic       wr_sts;
  logic       wr_msk;
  logic       enc_dis_req;
  enc_mode_t  mode;
  logic       enc_req;
  logic [IRQ_W-1:0] irq_evt;

  // ==========================================================
  // address decode, shared by writes and reads
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // helpers
  pin_sync3
  #(
    .WIDTH (1)
  )
  u_inband_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .pin_in   (inband_encrypt_pin),
    .pin_out  (inband_sync)
  );

  receiver_wait_timer
  #(
    .CYCLES (WAIT_COUNT)
  )
  u_wait
  (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .start       (cipher_init_evt),
    .abort       (st_ff.rst_p | st_ff.stop_p),
    .wait_enable (st_ff.cfg[CFG_WAIT]), // R2
    .busy        (wait_busy),
    .done        (wait_done)
  );

  // ==========================================================
  // decode and derived terms
  assign wr_cfg      = reg_wr && hit(reg_addr, CONFIG_OFS);
  assign wr_ctl      = reg_wr && hit(reg_addr, CONTROL_OFS);
  assign wr_sts      = reg_wr && hit(reg_addr, IRQ_STATUS_OFS);
  assign wr_msk      = reg_wr && hit(reg_addr, IRQ_MASK_OFS);
  assign enc_dis_req = wr_ctl && reg_wdata[CTL_ENC_DIS];
  assign mode        = enc_mode_t'(st_ff.cfg[CFG_MODE_HI:CFG_MODE_LO]);

  // encryption request per mode
  always_comb
  begin
    case (mode) // R1
      MODE_AUTHENTICATED:
        enc_req = authenticated;
      MODE_REGISTER:
        enc_req = st_ff.enc_en; // R9
      MODE_ALWAYS:
        enc_req = 1'b1;
      MODE_PER_FRAME_INBAND:
        enc_req = st_ff.inband;
      default:
        enc_req = 1'b0;
    endcase
  end

  assign irq_evt[IRQ_KEY_READY]  = key_read_evt;
  assign irq_evt[IRQ_LIST_READY] = list_read_evt;
  assign irq_evt[IRQ_AUTHED]     = authenticated && !st_ff.authed_d;
  assign irq_evt[IRQ_WAIT_DONE]  = wait_done;

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st            = st_ff;
    nxt_st.rst_p      = 1'b0;
    nxt_st.start_p    = 1'b0;
    nxt_st.restart_p  = 1'b0;
    nxt_st.stop_p     = 1'b0;
    nxt_st.key_rel_p  = 1'b0;
    nxt_st.list_rel_p = 1'b0;
    nxt_st.authed_d   = authenticated;

    // configuration: only implemented bits are stored
    if (wr_cfg)
      nxt_st.cfg = reg_wdata & CFG_MASK;

    // authentication enable, restart, disable and reset
    if (wr_ctl && reg_wdata[CTL_PROT_RST])
    begin
      nxt_st.rst_p   = 1'b1; // R5
      nxt_st.auth_en = 1'b0; // R5
    end
    else if (wr_ctl && reg_wdata[CTL_AUTH_DIS])
    begin
      nxt_st.stop_p  = 1'b1; // R12
      nxt_st.auth_en = 1'b0; // R12
    end
    else if (wr_ctl && reg_wdata[CTL_AUTH_EN])
    begin
      nxt_st.auth_en   = 1'b1;            // R13
      nxt_st.start_p   = !st_ff.auth_en;  // R13
      nxt_st.restart_p = st_ff.auth_en;   // R13
    end

    // encryption enable: fixed high in always mode, disable wins
    if (mode == MODE_ALWAYS)
      nxt_st.enc_en = 1'b1; // R10
    else if (enc_dis_req)
      nxt_st.enc_en = 1'b0; // R8
    else if (wr_ctl)
      nxt_st.enc_en = reg_wdata[CTL_ENC_EN]; // R9

    // key ready flag and approval handshake
    if (key_read_evt)
      nxt_st.key_rdy = 1'b1; // R15
    if (wr_ctl && reg_wdata[CTL_KEY_OK])
      nxt_st.key_ok = 1'b1; // R7
    if (st_ff.key_rdy && st_ff.key_ok && !key_read_evt)
    begin
      nxt_st.key_rel_p = 1'b1;
      nxt_st.key_rdy   = 1'b0;
      nxt_st.key_ok    = 1'b0; // R7
    end

    // repeater list ready flag and approval handshake
    if (list_read_evt)
      nxt_st.list_rdy = 1'b1; // R16
    if (wr_ctl && reg_wdata[CTL_LIST_OK])
      nxt_st.list_ok = 1'b1; // R6
    if (st_ff.list_rdy && st_ff.list_ok && !list_read_evt)
    begin
      nxt_st.list_rel_p = 1'b1; // R6
      nxt_st.list_rdy   = 1'b0;
      nxt_st.list_ok    = 1'b0; // R6
    end

    // a reset or disable drops any handshake in flight
    if (st_ff.rst_p || st_ff.stop_p)
    begin
      nxt_st.key_rdy  = 1'b0;
      nxt_st.key_ok   = 1'b0;
      nxt_st.list_rdy = 1'b0;
      nxt_st.list_ok  = 1'b0;
    end

    // in-band request only changes at a frame boundary
    if (frame_start)
      nxt_st.inband = inband_sync; // R1

    // video path; mute freezes the encryption state as it stands, except that an encryption disable write still clears it
    nxt_st.mute = st_ff.cfg[CFG_MUTE]; // R3
    nxt_st.enh  = st_ff.cfg[CFG_ENH_SEL]; // R14
    if (!st_ff.cfg[CFG_MUTE])
    begin
      nxt_st.encrypt = enc_req && authenticated && !wait_busy; // R9
      nxt_st.blue    = enc_req && !authenticated; // R9
    end
    if (enc_dis_req)
    begin
      // plain video now, authentication untouched
      nxt_st.encrypt = 1'b0; // R8
      nxt_st.blue    = 1'b0;
    end
    nxt_st.paused  = (st_ff.key_rdy && !is_repeater) || st_ff.list_rdy; // R15
    nxt_st.waiting = wait_busy; // R2

    // interrupt status: a new event wins over a write-one clear
    if (wr_sts)
      nxt_st.irq_sts = st_ff.irq_sts & ~reg_wdata[IRQ_W-1:0];
    nxt_st.irq_sts = nxt_st.irq_sts | irq_evt;
    if (wr_msk)
      nxt_st.irq_mask = reg_wdata[IRQ_W-1:0];
    nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_mask);

    // read data, valid the cycle after the read strobe
    nxt_st.rdata = '0;
    if (reg_rd)
    begin
      if (hit(reg_addr, CONFIG_OFS))
        nxt_st.rdata = st_ff.cfg;
      else if (hit(reg_addr, CONTROL_OFS))
      begin
        // pulse-type bits are never held, so they read zero
        nxt_st.rdata[CTL_LIST_OK] = st_ff.list_ok; // R17
        nxt_st.rdata[CTL_KEY_OK]  = st_ff.key_ok;
        nxt_st.rdata[CTL_ENC_EN]  = st_ff.enc_en || mode == MODE_ALWAYS;
        nxt_st.rdata[CTL_AUTH_EN] = st_ff.auth_en; // R13
      end
      else if (hit(reg_addr, IRQ_STATUS_OFS))
        nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.irq_sts};
      else if (hit(reg_addr, IRQ_MASK_OFS))
        nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_ff.irq_mask};
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_ff          <= '0;
      st_ff.cfg      <= CFG_RESET;
      st_ff.irq_sts  <= IRQ_RESET;
      st_ff.irq_mask <= IRQ_RESET;
    end
    else if (clk_en)
      st_ff <= nxt_st;
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign reg_rdata           = st_ff.rdata;
  assign protect_reset       = st_ff.rst_p;
  assign auth_start          = st_ff.start_p;
  assign auth_restart        = st_ff.restart_p;
  assign auth_stop           = st_ff.stop_p;
  assign auth_paused         = st_ff.paused;
  assign key_release         = st_ff.key_rel_p;
  assign list_release        = st_ff.list_rel_p;
  assign encrypt_on          = st_ff.encrypt;
  assign blue_screen         = st_ff.blue;
  assign mute_active         = st_ff.mute;
  assign enhanced_signalling = st_ff.enh;
  assign cipher_wait         = st_ff.waiting;
  assign irq                 = st_ff.irq;

endmodule

// ### include/protect_ctl_pkg.sv
/*
  constants, field positions, reset values and timing counts for the
  content-protection transmitter control block.
  assumes: one 10 MHz register clock, byte-wide register port.
*/
package protect_ctl_pkg;

  // ==========================================================
  // register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] CONFIG_OFS     = 8'hc2;
  localparam logic [7:0] CONTROL_OFS    = 8'hc3;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'hd0;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'hd1;

  // ==========================================================
  // protect_config_low fields
  localparam int unsigned CFG_ENH_SEL = 6;
  localparam int unsigned CFG_MODE_HI = 4;
  localparam int unsigned CFG_MODE_LO = 3;
  localparam int unsigned CFG_WAIT    = 2;
  localparam int unsigned CFG_MUTE    = 0;
  localparam logic [7:0]  CFG_MASK    = 8'h5d;
  localparam logic [7:0]  CFG_RESET   = 8'h08;

  // ==========================================================
  // protect_control fields
  localparam int unsigned CTL_PROT_RST = 7;
  localparam int unsigned CTL_LIST_OK  = 5;
  localparam int unsigned CTL_KEY_OK   = 4;
  localparam int unsigned CTL_ENC_DIS  = 3;
  localparam int unsigned CTL_ENC_EN   = 2;
  localparam int unsigned CTL_AUTH_DIS = 1;
  localparam int unsigned CTL_AUTH_EN  = 0;
  localparam logic [7:0]  CTL_RESET    = 8'h00;

  // ==========================================================
  // interrupt status / mask bits
  localparam int unsigned IRQ_KEY_READY  = 0;
  localparam int unsigned IRQ_LIST_READY = 1;
  localparam int unsigned IRQ_AUTHED     = 2;
  localparam int unsigned IRQ_WAIT_DONE  = 3;
  localparam int unsigned IRQ_W          = 4;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;

  // ==========================================================
  // encryption control modes
  typedef enum logic [1:0]
  {
    MODE_AUTHENTICATED    = 2'h0,
    MODE_REGISTER         = 2'h1,
    MODE_ALWAYS           = 2'h2,
    MODE_PER_FRAME_INBAND = 2'h3
  } enc_mode_t;

  // ==========================================================
  // receiver wait timer
  typedef enum logic [1:0]
  {
    WAIT_IDLE = 2'h0,
    WAIT_RUN  = 2'h1,
    WAIT_DONE = 2'h3
  } wait_state_t;

  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned WAIT_TIME_MS = 100;
  localparam int unsigned WAIT_CYCLES  = WAIT_TIME_MS * (CLK_HZ / 1000);

endpackage

// ### design/pin_sync3.sv
/*
  three-stage input synchroniser with agreement filter.
  assumes: inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ns
module pin_sync3
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // pins and result
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_t;

  sync_t            st_ff;
  sync_t            nxt_st;
  logic [WIDTH-1:0] agree;

  // ==========================================================
  // per-bit agreement of stages two and three
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign agree[i] = (st_ff.s2[i] == st_ff.s3[i]);
    end
  endgenerate

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.q  = (st_ff.s3 & agree) | (st_ff.q & ~agree);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign pin_out = st_ff.q;

endmodule

// ### design/receiver_wait_timer.sv
/*
  receiver wait timer: optional fixed wait before encryption starts.
  assumes: start is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ns
module receiver_wait_timer
  import protect_ctl_pkg::*;
#(
  parameter int unsigned CYCLES = WAIT_CYCLES,
  parameter int unsigned CNT_W  = $clog2(CYCLES + 1)
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // control
  input  wire logic start,
  input  wire logic abort,
  input  wire logic wait_enable,
  // status
  output logic      busy,
  output logic      done
);

  typedef struct packed
  {
    wait_state_t      state;
    logic [CNT_W-1:0] count;
  } timer_t;

  timer_t st_ff;
  timer_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff.state)
      WAIT_IDLE:
      begin
        if (start && !abort)
        begin
          // with the wait off the done pulse follows at once
          nxt_st.count = CNT_W'(CYCLES - 1);
          nxt_st.state = wait_enable ? WAIT_RUN : WAIT_DONE;
        end
      end
      WAIT_RUN:
      begin
        if (abort)
          nxt_st.state = WAIT_IDLE;
        else if (st_ff.count == '0)
          nxt_st.state = WAIT_DONE;
        else
          nxt_st.count = st_ff.count - CNT_W'(1);
      end
      WAIT_DONE:
        nxt_st.state = WAIT_IDLE;
      default:
        nxt_st.state = WAIT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_ff <= '{state: WAIT_IDLE, count: '0};
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign busy = (st_ff.state == WAIT_RUN);
  assign done = (st_ff.state == WAIT_DONE);

endmodule

// ### tb/protect_ctl_checker.sv
/*
  assertions on the content-protection control block ports.
  assumes: bound to content_protect_tx_control, one clock, sync reset.
*/
`timescale 1ns/1ns
module protect_ctl_checker
  import protect_ctl_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // engine side
  input wire logic              is_repeater,
  input wire logic              key_read_evt,
  input wire logic              protect_reset,
  input wire logic              auth_start,
  input wire logic              auth_restart,
  input wire logic              auth_stop,
  input wire logic              auth_paused,
  input wire logic              key_release,
  // video and interrupt
  input wire logic              encrypt_on,
  input wire logic              blue_screen,
  input wire logic              mute_active,
  input wire logic              enhanced_signalling,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic ctl_wr;
  logic quiet;
  assign ctl_wr = reg_wr && clk_en && reg_addr == CONTROL_OFS;
  // a write or a reset pulse may clear the flags, so keep them out
  assign quiet = clk_en && !is_repeater && !reg_wr && !protect_reset
                 && !auth_stop;

  // ==========================================================
  // key handshake
  sequence s_key_seen;
    key_read_evt && quiet ##1 quiet;
  endsequence

  a_key_pause: assert property (s_key_seen |=> auth_paused)
    else $error("pause missing after key read");
  a_release_pulse: assert property (key_release |=> !key_release)
    else $error("key release longer than one cycle");

  // ==========================================================
  // commands and register port
  a_reset_pulse: assert property (ctl_wr && reg_wdata[CTL_PROT_RST]
    |=> protect_reset && !auth_start)
    else $error("reset pulse missing");
  a_stop_pulse: assert property (ctl_wr && !reg_wdata[CTL_PROT_RST]
    && reg_wdata[CTL_AUTH_DIS] |=> auth_stop && !auth_start)
    else $error("stop pulse missing");
  a_enable_pulse: assert property (ctl_wr && reg_wdata[1:0] == 2'h1
    && !reg_wdata[CTL_PROT_RST]
    |=> (auth_start != auth_restart))
    else $error("start or restart pulse missing");
  a_rdata_idle: assert property (!reg_rd && clk_en
    |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_ctl_reserved: assert property (reg_rd && reg_addr == CONTROL_OFS
    |=> (reg_rdata & 8'hca) == 8'h00)
    else $error("control self-clearing bit reads one");
  a_cfg_reserved: assert property (reg_rd && reg_addr == CONFIG_OFS
    |=> (reg_rdata & 8'ha2) == 8'h00)
    else $error("config unused bit reads one");

  // ==========================================================
  // video path and interrupt
  a_enc_off: assert property (ctl_wr && reg_wdata[CTL_ENC_DIS]
    |-> ##[1:2] !encrypt_on && !blue_screen)
    else $error("encryption not dropped");
  a_cfg_copy: assert property (reg_wr && clk_en
    && reg_addr == CONFIG_OFS
    |-> ##2 mute_active == $past(reg_wdata[CFG_MUTE], 2)
    && enhanced_signalling == $past(reg_wdata[CFG_ENH_SEL], 2))
    else $error("mute or signalling select wrong");
  a_irq_masked: assert property (reg_wr && clk_en
    && reg_addr == IRQ_MASK_OFS && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt despite full mask");
endmodule

bind content_protect_tx_control protect_ctl_checker i_chk (
  .core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .is_repeater, .key_read_evt, .protect_reset, .auth_start,
  .auth_restart, .auth_stop, .auth_paused, .key_release, .encrypt_on,
  .blue_screen, .mute_active, .enhanced_signalling, .irq
);

// ### tb/tb_top.sv
/*
  self-checking bench for the content-protection control block.
  assumes: 10 MHz clock, timer shortened through WAIT_COUNT.
*/
`timescale 1ns/1ns
module tb_top
  import protect_ctl_pkg::*;
;
  localparam int WAIT_N = 20;
  localparam logic [7:0] CMD [7] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h01,
                                     8'h80, 8'h83};
  localparam logic [3:0] PUL [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h1,
                                     4'h8, 4'h8};
  typedef struct {string name; logic [7:0] val;} note_t;
  note_t notes[$];
  note_t note;
  int fails = 0;
  int checks = 0;
  int cnt;
  logic core_clk = 0, rst_n = 0, clk_en = 1, rd_seen = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, cfg;
  logic reg_wr = 0, reg_rd = 0, is_repeater = 0, authenticated = 0;
  logic key_read_evt = 0, list_read_evt = 0, cipher_init_evt = 0;
  logic frame_start = 0, inband_encrypt_pin = 0, en, au, ib, req;
  logic [7:0] reg_rdata;
  logic protect_reset, auth_start, auth_restart, auth_stop, auth_paused;
  logic key_release, list_release, encrypt_on, blue_screen, mute_active;
  logic enhanced_signalling, cipher_wait, irq;

  content_protect_tx_control #(.WAIT_COUNT(WAIT_N)) i_dut (
    .core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .is_repeater, .authenticated, .key_read_evt,
    .list_read_evt, .cipher_init_evt, .frame_start, .inband_encrypt_pin,
    .protect_reset, .auth_start, .auth_restart, .auth_stop, .auth_paused,
    .key_release, .list_release, .encrypt_on, .blue_screen, .mute_active,
    .enhanced_signalling, .cipher_wait, .irq
  );

  always #50 core_clk = ~core_clk;

  // ==========================================================
  // drivers and comparison
  task automatic op(input logic w, input logic r, input logic [7:0] a,
                    input logic [7:0] d, input logic [3:0] ev);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    {frame_start, cipher_init_evt, list_read_evt, key_read_evt} <= ev;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d, 4'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    notes.push_back('{n, e});
    op(1'b0, 1'b1, a, 8'h00, 4'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00, 4'h0);
  endtask
  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rd_seen)
    begin
      note = notes.pop_front();
      check(note.name, reg_rdata, note.val);
    end
    rd_seen <= reg_rd;
  end

  initial
  begin
    #(100 * 5000);
    fails++;
    final_report();
  end

  // ==========================================================
  // scenarios
  initial
  begin
    void'($urandom(84245));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    idle(1);
    rd(CONFIG_OFS, CFG_RESET, "cfg");
    rd(CONTROL_OFS, CTL_RESET, "ctl");
    rd(IRQ_STATUS_OFS, 8'h00, "status");
    rd(IRQ_MASK_OFS, 8'h00, "mask");
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00, "unmapped");
    for (int m = 0; m < 4; m++)
    begin
      en = 1'($urandom);
      au = 1'($urandom);
      ib = 1'($urandom);
      authenticated <= au;
      inband_encrypt_pin <= ib;
      cfg = {1'b0, 1'($urandom), 1'b0, 2'(m), 1'($urandom), 2'b00};
      wr(CONFIG_OFS, cfg);
      wr(CONTROL_OFS, {5'h00, en, 2'b00});
      rd(CONFIG_OFS, cfg, "cfg");
      rd(CONTROL_OFS, {5'h00, (m == 2) | en, 2'b00}, "ctl");
      idle(6);
      op(1'b0, 1'b0, 8'h00, 8'h00, 4'h8);
      idle(3);
      req = (m == 0) ? au : (m == 1) ? en : (m == 2) ? 1'b1 : ib;
      check("encrypt_on", 8'(encrypt_on), 8'(req & au));
      check("blue_screen", 8'(blue_screen), 8'(req & ~au));
    end
    authenticated <= 1'b1;
    wr(CONFIG_OFS, 8'h08);
    wr(CONTROL_OFS, 8'h04);
    idle(3);
    check("encrypt_on", 8'(encrypt_on), 8'h01);
    wr(CONTROL_OFS, 8'h08);
    idle(2);
    check("encrypt_on", 8'(encrypt_on), 8'h00);
    rd(CONTROL_OFS, 8'h00, "ctl");
    wr(CONFIG_OFS, 8'h49);
    idle(2);
    check("mute", 8'({enhanced_signalling, mute_active}), 8'h03);
    wr(CONTROL_OFS, 8'h04);
    idle(3);
    check("encrypt_on", 8'(encrypt_on), 8'h00);
    wr(CONFIG_OFS, 8'h08);
    idle(3);
    check("encrypt_on", 8'(encrypt_on), 8'h01);
    for (int i = 0; i < 7; i++)
    begin
      wr(CONTROL_OFS, CMD[i]);
      idle(1);
      check("pulses", 8'({protect_reset, auth_stop, auth_restart,
            auth_start}), 8'(PUL[i]));
      rd(CONTROL_OFS, 8'(PUL[i][1:0] != 2'h0), "ctl");
    end
    for (int k = 0; k < 2; k++)
    begin
      is_repeater <= 1'(k);
      wr(IRQ_STATUS_OFS, 8'h0f);
      wr(IRQ_MASK_OFS, 8'h03);
      op(1'b0, 1'b0, 8'h00, 8'h00, 4'(1 << k));
      idle(2);
      check("auth_paused", 8'(auth_paused), 8'h01);
      check("irq", 8'(irq), 8'h01);
      rd(IRQ_STATUS_OFS, 8'(1 << k), "status");
      wr(CONTROL_OFS, 8'(8'h10 << k));
      idle(2);
      check("release", 8'({list_release, key_release}), 8'(1 << k));
      rd(CONTROL_OFS, 8'h00, "ctl");
      wr(IRQ_STATUS_OFS, 8'h0f);
      idle(2);
      check("irq", 8'(irq), 8'h00);
    end
    is_repeater <= 1'b0;
    wr(IRQ_MASK_OFS, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00, 4'h1);
    idle(2);
    check("irq", 8'(irq), 8'h00);
    wr(IRQ_MASK_OFS, 8'h01);
    idle(2);
    check("irq", 8'(irq), 8'h01);
    for (int w = 1; w >= 0; w--)
    begin
      wr(IRQ_STATUS_OFS, 8'h0f);
      wr(CONFIG_OFS, {5'h00, 1'(w), 2'b00});
      op(1'b0, 1'b0, 8'h00, 8'h00, 4'h4);
      cnt = 0;
      for (int i = 0; i < WAIT_N + 10; i++)
      begin
        idle(1);
        cnt += int'(cipher_wait);
        if (i == 5)
          check("encrypt_on", 8'(encrypt_on), 8'(w == 0));
      end
      check("wait", 8'(cnt), (w == 1) ? 8'(WAIT_N) : 8'h00);
      check("encrypt_on", 8'(encrypt_on), 8'h01);
      rd(IRQ_STATUS_OFS, 8'h08, "status");
    end
    // a write while the enable is low must leave no trace
    clk_en <= 1'b0;
    wr(CONFIG_OFS, 8'h49);
    clk_en <= 1'b1;
    rd(CONFIG_OFS, 8'h00, "cfg frozen");
    idle(2);
    final_report();
  end
endmodule
